// [rtl/wcsseq_pkg.sv]
// shared constants and types for the writable control store sequencer
package wcsseq_pkg;
  // ==========================================================
  // widths
  localparam int ADDR_W = 11;
  localparam int WORD_W = 24;
  localparam int RAM_AW = 10;
  localparam int BLOCK_AW = 9;
  localparam int SW_W = 7;

  // ==========================================================
  // register offsets (byte addresses)
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_LOAD_ADDR = 8'h04;
  localparam logic [7:0] REG_LOAD_DATA = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0C;
  localparam int CTRL_ENABLE_BIT = 12;
  localparam logic CTRL_ENABLE_RESET = 1'b0;
  localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;

  // ==========================================================
  // microword fields
  localparam int STD_CODE_LSB = 18;
  localparam int EXT_CODE_LSB = 22;
  localparam int TRACE_BIT = 23;
  localparam int RETURN_TO_SERVICE_BIT = 17;
  localparam int LOAD_RETURN_REGISTER_BIT = 16;
  localparam int OP_LSB = 12;
  localparam int RETURN_SEL_BIT = 11;
  localparam int COND_SEL_LSB = 8;
  localparam logic [3:0] OP_JUMP_GROUP = 4'h0;
  localparam logic [3:0] OP_COND_GROUP = 4'h1;
  localparam logic [3:0] PAGE_SWAP_CODE = 4'h7;

  // ==========================================================
  // address range switch patterns, bit 0 is S1, switch on reads 1
  localparam logic [6:0] SW_MODE_ONE = 7'h29;
  localparam logic [6:0] SW_MODE_TWO = 7'h4A;
  localparam logic [6:0] SW_MODE_THREE = 7'h2C;
  localparam logic [6:0] SW_MODE_FOUR = 7'h31;

  typedef enum logic [2:0] {MODE_OFF, MODE_ONE, MODE_TWO, MODE_THREE, MODE_FOUR} wcsseq_mode_t;
endpackage

// [rtl/wcsseq_ram_if.sv]
// port bundle between the sequencer and its control store memory
`timescale 1ns/1ps
`default_nettype none
interface wcsseq_ram_if;
  logic writeEn;
  logic [wcsseq_pkg::RAM_AW-1:0] writeAddr;
  logic [wcsseq_pkg::WORD_W-1:0] writeData;
  logic [wcsseq_pkg::RAM_AW-1:0] readAddr;
  logic [wcsseq_pkg::WORD_W-1:0] readData;
  modport ctl (output writeEn, output writeAddr, output writeData, output readAddr, input readData);
  modport ram (input writeEn, input writeAddr, input writeData, input readAddr, output readData);
endinterface
`default_nettype wire

// [rtl/wcsseq_ram.sv]
// control store memory, one write port, registered read port
`timescale 1ns/1ps
`default_nettype none
module wcsseq_ram #(
  parameter int DEPTH = 1024
) (
  input wire logic ref_clk,
  wcsseq_ram_if.ram port
);
  // ==========================================================
  // storage
  if (DEPTH != (1 << wcsseq_pkg::RAM_AW))
  begin : depthCheck
    $error("depth must match the load address width");
  end

  logic [wcsseq_pkg::WORD_W-1:0] store [DEPTH];
  logic [wcsseq_pkg::WORD_W-1:0] readReg;

  // no reset on the array; read data is undefined until a loaded location is read
  always_ff @(posedge ref_clk)
  begin
    if (port.writeEn)
      store[port.writeAddr] <= port.writeData;
    readReg <= store[port.readAddr];
  end

  assign port.readData = readReg;
endmodule
`default_nettype wire

// [rtl/wcsseq_top.sv]
// writable control store with microsequencer and wishbone load port
//
// The Wishbone slave port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - each microword carries a 4-bit external control code in bits 21..18
// - microword bits 22 and 23 are driven out as extended controls
// - bit 23 also feeds trace logic without altering its outside value
// - service bit set: run the next word, then enter the service sequence unless that word jumps, returns or takes a conditional jump
// - a jump or return overrides any fixed-address translation
// - call loads full counter from bits 10..0, saves counter plus one
// - return loads full counter from the return register
// - taken conditional jump replaces low 8 bits, keeps upper 3 incremented
// - store answers only when enabled, range set by switches S1..S7
// - mode one: addresses 2000..3777 octal read RAM words 0..1777
// - mode two: addresses 3000..3777 octal, first block after setup
// - mode two: code 7 toggles the active 512-word block
// - mode three: as mode one with the two blocks exchanged
// - mode four: addresses 0..1777 octal read RAM words 0..1777
// - enable is control bit 12; mode four output ORs with base word
module wcsseq_top #(
  parameter logic [10:0] SERVICE_ADDR = 11'h001
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [6:0] addressRangeSwitch,
  input wire logic [23:0] microwordIn,
  output logic [23:0] microwordOut,
  output logic microwordOe,
  output logic [10:0] microAddr,
  input wire logic [15:0] condFlags,
  input wire logic xlatReq,
  input wire logic [10:0] xlatAddr,
  output logic [3:0] stdControl,
  output logic [1:0] extControl,
  output logic traceBit,
  output logic serviceEntry
);
  // ==========================================================
  // switch synchroniser and mode decode
  logic [6:0] swMeta;
  logic [6:0] swSync2;
  logic [6:0] swSync3;
  logic [6:0] swStable;
  wcsseq_pkg::wcsseq_mode_t modeSel;

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      swMeta <= 7'h00;
      swSync2 <= 7'h00;
      swSync3 <= 7'h00;
      swStable <= 7'h00;
    end
    else
    begin
      swMeta <= addressRangeSwitch;
      swSync2 <= swMeta;
      swSync3 <= swSync2;
      if (swSync2 == swSync3)
        swStable <= swSync3;
    end
  end

  assign modeSel = (swStable == wcsseq_pkg::SW_MODE_ONE) ? wcsseq_pkg::MODE_ONE :
                   (swStable == wcsseq_pkg::SW_MODE_TWO) ? wcsseq_pkg::MODE_TWO :
                   (swStable == wcsseq_pkg::SW_MODE_THREE) ? wcsseq_pkg::MODE_THREE :
                   (swStable == wcsseq_pkg::SW_MODE_FOUR) ? wcsseq_pkg::MODE_FOUR : wcsseq_pkg::MODE_OFF;

  // ==========================================================
  // wishbone slave
  logic storeEnable;
  logic [9:0] loadAddr;
  logic [23:0] loadShadow;
  wire busReq = wb_cyc_i && wb_stb_i;
  wire busWrite = busReq && wb_we_i && wb_ack_o;
  wire selCtrl = (wb_adr_i == wcsseq_pkg::REG_CTRL);
  wire selAddr = (wb_adr_i == wcsseq_pkg::REG_LOAD_ADDR);
  wire selData = (wb_adr_i == wcsseq_pkg::REG_LOAD_DATA);
  wire selStatus = (wb_adr_i == wcsseq_pkg::REG_STATUS);
  wire [31:0] laneMask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  wire [31:0] ctrlWord = {19'h0_0000, storeEnable, 12'h000};
  wire [31:0] addrWord = {22'h00_0000, loadAddr};
  wire [31:0] dataWord = {8'h00, loadShadow};
  wire [31:0] mergedCtrl = (ctrlWord & ~laneMask) | (wb_dat_i & laneMask);
  wire [31:0] mergedAddr = (addrWord & ~laneMask) | (wb_dat_i & laneMask);
  wire [31:0] mergedData = (dataWord & ~laneMask) | (wb_dat_i & laneMask);
  wire ramLoad = busWrite && selData;
  logic svcPending;
  logic page;
  logic [10:0] lc;
  wire [31:0] statusWord = {14'h0000, page, svcPending, 1'b0, modeSel, lc[10:0], 1'b0};
  wire [31:0] readMux = selCtrl ? ctrlWord :
                        selAddr ? addrWord :
                        selData ? dataWord :
                        selStatus ? statusWord : wcsseq_pkg::UNMAPPED_READ;

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end
    else
    begin
      wb_ack_o <= busReq && !wb_ack_o;
      wb_dat_o <= readMux;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      storeEnable <= wcsseq_pkg::CTRL_ENABLE_RESET;
    else if (busWrite && selCtrl)
      storeEnable <= mergedCtrl[wcsseq_pkg::CTRL_ENABLE_BIT];
  end

  // data writes post-increment the load pointer so a block streams in
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      loadAddr <= 10'h000;
      loadShadow <= 24'h00_0000;
    end
    else if (busWrite && selAddr)
      loadAddr <= mergedAddr[9:0];
    else if (ramLoad)
    begin
      loadShadow <= mergedData[23:0];
      loadAddr <= loadAddr + 10'h001;
    end
  end

  // ==========================================================
  // fetched word and its decode
  wcsseq_ram_if ramPort();
  logic [23:0] fetchWord;
  wire modeFour = (modeSel == wcsseq_pkg::MODE_FOUR);
  wire modeTwo = (modeSel == wcsseq_pkg::MODE_TWO);

  // wired-or with base word in mode four
  assign fetchWord = microwordOe ? (modeFour ? (ramPort.readData | microwordIn) : ramPort.readData) : microwordIn;
  wire [3:0] opGroup = fetchWord[wcsseq_pkg::OP_LSB +: 4];
  wire isJump = (opGroup == wcsseq_pkg::OP_JUMP_GROUP) && !fetchWord[wcsseq_pkg::RETURN_SEL_BIT];
  wire isReturn = (opGroup == wcsseq_pkg::OP_JUMP_GROUP) && fetchWord[wcsseq_pkg::RETURN_SEL_BIT];
  wire isCall = isJump && fetchWord[wcsseq_pkg::LOAD_RETURN_REGISTER_BIT];
  wire condTaken = (opGroup == wcsseq_pkg::OP_COND_GROUP) && condFlags[fetchWord[wcsseq_pkg::COND_SEL_LSB +: 4]];
  wire [3:0] stdCode = fetchWord[wcsseq_pkg::STD_CODE_LSB +: 4];
  wire pageSwap = modeTwo && storeEnable && (stdCode == wcsseq_pkg::PAGE_SWAP_CODE);
  wire [10:0] lcInc = lc + 11'h001;

  // ==========================================================
  // next location
  logic [10:0] retReg;
  logic [10:0] next_lc;
  logic next_enterService;

  always_comb
  begin
    next_enterService = 1'b0;
    // jumps and returns win over translation
    if (isJump)
      next_lc = fetchWord[10:0];
    else if (isReturn)
      next_lc = retReg;
    else if (condTaken)
      next_lc = {lcInc[10:8], fetchWord[7:0]};
    // service entry after the following word
    else if (svcPending)
    begin
      next_lc = SERVICE_ADDR;
      next_enterService = 1'b1;
    end
    else if (xlatReq)
      next_lc = xlatAddr;
    else
      next_lc = lcInc;
  end

  wire next_page = storeEnable && (page ^ pageSwap);

  // ==========================================================
  // address mapping per mode
  // upper or lower half
  wire halfHit = (modeSel == wcsseq_pkg::MODE_ONE || modeSel == wcsseq_pkg::MODE_THREE) ? next_lc[10] :
                 modeFour ? !next_lc[10] : 1'b0;
  wire quarterHit = modeTwo && (next_lc[10:9] == 2'b11);
  // answer only when enabled and in range
  wire next_hit = storeEnable && (halfHit || quarterHit);
  wire [9:0] next_index = (modeSel == wcsseq_pkg::MODE_THREE) ? {~next_lc[9], next_lc[8:0]} :
                          modeTwo ? {next_page, next_lc[8:0]} : next_lc[9:0];

  assign ramPort.writeEn = ramLoad;
  assign ramPort.writeAddr = loadAddr;
  assign ramPort.writeData = mergedData[23:0];
  assign ramPort.readAddr = next_index;

  wcsseq_ram #(
    .DEPTH(1024)
  ) u_ram (
    .ref_clk(ref_clk),
    .port(ramPort.ram)
  );

  // the bus value is the memory's output register; the bus resolves the or
  assign microwordOut = ramPort.readData;

  // ==========================================================
  // sequencer state
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      lc <= 11'h000;
      microAddr <= 11'h000;
      page <= 1'b0;
      microwordOe <= 1'b0;
      serviceEntry <= 1'b0;
    end
    else
    begin
      lc <= next_lc;
      microAddr <= next_lc;
      page <= next_page;
      microwordOe <= next_hit;
      serviceEntry <= next_enterService;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      svcPending <= 1'b0;
    else
      svcPending <= fetchWord[wcsseq_pkg::RETURN_TO_SERVICE_BIT] && !svcPending;
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      retReg <= 11'h000;
    else if (isCall)
      retReg <= lcInc;
  end

  // control bits to the backplane, trace shares bit 23 read-only
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      stdControl <= 4'h0;
      extControl <= 2'h0;
      traceBit <= 1'b0;
    end
    else
    begin
      stdControl <= stdCode;
      extControl <= fetchWord[wcsseq_pkg::EXT_CODE_LSB +: 2];
      traceBit <= fetchWord[wcsseq_pkg::TRACE_BIT];
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  service_exit_a: assert property (svcPending && !isJump && !isReturn && !condTaken |=> lc == SERVICE_ADDR && serviceEntry)
    else $error("service entry missed");
  call_load_a: assert property (isCall |=> lc == $past(fetchWord[10:0]) && retReg == $past(lcInc))
    else $error("call did not load counter and return");
  return_load_a: assert property (isReturn |=> lc == $past(retReg))
    else $error("return did not restore counter");
  cond_page_a: assert property (condTaken && !isJump |=> lc[10:8] == $past(lcInc[10:8]) && lc[7:0] == $past(fetchWord[7:0]))
    else $error("conditional jump left page");
  jump_over_xlat_a: assert property (isJump && xlatReq |=> lc == $past(fetchWord[10:0]))
    else $error("translation overrode jump");
  bus_quiet_a: assert property (!storeEnable |=> !microwordOe)
    else $error("bus driven while disabled");
  mode_two_range_a: assert property (microwordOe && modeTwo && $stable(modeSel) |-> lc[10:9] == 2'b11)
    else $error("mode two answered outside range");
  mode_four_range_a: assert property (microwordOe && modeFour && $stable(modeSel) |-> !lc[10])
    else $error("mode four answered outside range");
  page_swap_a: assert property (pageSwap |=> page != $past(page))
    else $error("code 7 did not swap block");
  ctrl_out_a: assert property (##1 stdControl == $past(stdCode) && extControl == $past(fetchWord[23:22]))
    else $error("control bits not presented");
  trace_share_a: assert property (traceBit == extControl[1])
    else $error("trace bit differs from bit 23");

  call_seen_c: cover property (isCall ##[1:20] isReturn);
  swap_seen_c: cover property (pageSwap ##[1:20] pageSwap);
  service_seen_c: cover property (serviceEntry);
  mode_four_or_c: cover property (microwordOe && modeFour);
endmodule
`default_nettype wire

// [verification/wcsseq_proc_model.sv]
// processor side model: base microcode image, bus resolution, translations
`timescale 1ns/1ps
`default_nettype none
module wcsseq_proc_model (
  input wire logic [10:0] microAddr,
  input wire logic [23:0] microwordOut,
  input wire logic microwordOe,
  output logic [23:0] microwordIn,
  output logic xlatReq,
  output logic [10:0] xlatAddr
);
  // ==========================================================
  // base image
  // all zero words jump to 0, so an idle core parks in a one-word loop
  logic [23:0] baseRom [0:2047];
  initial
  begin
    foreach (baseRom[i])
      baseRom[i] = 24'h00_0000;
  end
  assign microwordIn = baseRom[microAddr] | (microwordOe ? microwordOut : 24'h00_0000);
  assign xlatReq = (microAddr == 11'h41B) || (microAddr == 11'h5EC);
  assign xlatAddr = 11'h000;
endmodule
`default_nettype wire

// [verification/tb.sv]
// bench: wishbone loading, four address modes, sequencing against a reference
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam logic [10:0] SVC = 11'h001;
  logic ref_clk = 0, rst_n = 0, cyc = 0, stb = 0, we = 0, ack, oe, xReq, trc, svc;
  logic [7:0] adr = 0;
  logic [31:0] wdat = 0, rdat;
  logic [6:0] sw = 0;
  logic [15:0] cond = 0;
  logic [23:0] mIn, mOut, w;
  logic [10:0] addr, xAddr, nl, inc;
  logic [3:0] std;
  logic [1:0] ext;
  int failures = 0, total_checks = 0, mMode = 0;
  logic [23:0] img [0:1023];
  logic [10:0] mLc = 0, mRet = 0;
  logic [3:0] mStd = 0;
  logic [1:0] mExt = 0;
  logic mPage = 0, mArm = 0, mEn = 0, mSvc = 0, mTrc = 0, run = 0;
  wcsseq_top #(.SERVICE_ADDR(SVC)) dut (.ref_clk(ref_clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .addressRangeSwitch(sw), .microwordIn(mIn), .microwordOut(mOut), .microwordOe(oe), .microAddr(addr),
    .condFlags(cond), .xlatReq(xReq), .xlatAddr(xAddr), .stdControl(std), .extControl(ext),
    .traceBit(trc), .serviceEntry(svc));
  wcsseq_proc_model proc (.microAddr(addr), .microwordOut(mOut), .microwordOe(oe), .microwordIn(mIn),
    .xlatReq(xReq), .xlatAddr(xAddr));
  always #5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) cond <= 16'($urandom);
  // ==========================================================
  // reporting and bus access
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (e !== g)
    begin
      failures++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    int n;
    @(posedge ref_clk);
    {cyc, stb, we, adr, wdat} <= {2'b11, wr, a, d};
    for (n = 0; n < 20 && ack !== 1'b1; n++)
      @(posedge ref_clk);
    r = rdat;
    {cyc, stb} <= 2'b00;
    if (n == 20)
    begin
      failures++;
      summarize();
    end
  endtask
  // ==========================================================
  // reference sequencer
  function automatic logic inRange(logic [10:0] a);
    case (mMode)
      1, 3: return a[10];
      2: return a[10:9] == 2'b11;
      4: return !a[10];
      default: return 1'b0;
    endcase
  endfunction
  function automatic logic [9:0] ramIdx(logic [10:0] a);
    case (mMode)
      2: return {mPage, a[8:0]};
      3: return {~a[9], a[8:0]};
      default: return a[9:0];
    endcase
  endfunction
  function automatic logic [23:0] fetchW(logic [10:0] a);
    if (!(mEn && inRange(a)))
      return proc.baseRom[a];
    return (mMode == 4) ? (img[ramIdx(a)] | proc.baseRom[a]) : img[ramIdx(a)];
  endfunction
  always @(posedge ref_clk)
    if (run)
    begin
      w = fetchW(mLc);
      inc = mLc + 11'd1;
      mSvc = 1'b0;
      nl = inc;
      if (mMode == 2 && mEn && inRange(mLc) && w[21:18] == 4'h7)
        mPage = ~mPage;
      if (w[15:11] == 5'h00)
      begin
        nl = w[10:0];
        if (w[16])
          mRet = inc;
      end
      else if (w[15:11] == 5'h01)
        nl = mRet;
      else if (w[15:12] == 4'h1 && cond[w[11:8]])
        nl = {inc[10:8], w[7:0]};
      else if (mArm)
        {nl, mSvc} = {SVC, 1'b1};
      else if (mLc == 11'h41B || mLc == 11'h5EC)
        nl = 11'h000;
      mArm = !mArm && w[17];
      {mTrc, mExt, mStd, mLc} = {w[23], w[23:22], w[21:18], nl};
    end
  always @(negedge ref_clk)
    if (run)
    begin
      chk("microAddr", 32'(mLc), 32'(addr));
      chk("microwordOe", 32'(mEn && inRange(mLc)), 32'(oe));
      chk("stdControl", 32'(mStd), 32'(std));
      chk("extControl", 32'(mExt), 32'(ext));
      chk("traceBit", 32'(mTrc), 32'(trc));
      chk("serviceEntry", 32'(mSvc), 32'(svc));
      if (oe === 1'b1)
        chk("microwordOut", 32'(img[ramIdx(mLc)]), 32'(mOut));
    end
  // ==========================================================
  // scenario helpers
  function automatic void put(logic [10:0] a, logic [23:0] d);
    img[ramIdx(a)] = d;
  endfunction
  function automatic logic [23:0] filler(int i);
    logic [3:0] codes [6] = '{4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h8};
    logic [23:0] f;
    f = {2'($urandom), codes[$urandom % 6], 2'b00, 4'(2 + $urandom % 14), 12'($urandom)};
    // forward jumps only, clear of page ends
    if (i % 8 == 3 && i[7:0] < 8'hF0)
      f[15:0] = {4'h1, 4'($urandom), 8'hF8};
    return f;
  endfunction
  task automatic setMode(input logic [6:0] s, input int m);
    logic [31:0] r;
    wb(1, wcsseq_pkg::REG_CTRL, 0, r);
    {mEn, mPage} = 2'b00;
    sw <= s;
    mMode = m;
    repeat (8) @(posedge ref_clk);
    wb(0, wcsseq_pkg::REG_STATUS, 0, r);
    chk("mode", 32'(m), (r >> 12) & 32'h0000_0007);
    for (int i = 0; i < 1024; i++)
      img[i] = filler(i);
  endtask
  task automatic load();
    logic [31:0] r;
    wb(1, wcsseq_pkg::REG_LOAD_ADDR, 0, r);
    for (int i = 0; i < 1024; i++)
      wb(1, wcsseq_pkg::REG_LOAD_DATA, 32'(img[i]), r);
    wb(0, wcsseq_pkg::REG_LOAD_DATA, 0, r);
    chk("last load", 32'(img[1023]), r);
  endtask
  task automatic enable();
    logic [31:0] r;
    wb(1, wcsseq_pkg::REG_CTRL, 32'h0000_1000, r);
    wb(0, wcsseq_pkg::REG_CTRL, 0, r);
    chk("enable", 1, 32'(r[wcsseq_pkg::CTRL_ENABLE_BIT]));
    mEn = 1'b1;
    repeat (4) @(posedge ref_clk);
  endtask
  // start word in the idle loop, then follow until it parks again
  task automatic go(input logic [10:0] s);
    int n;
    @(posedge ref_clk);
    proc.baseRom[0] <= 24'(s);
    run <= 1'b1;
    @(posedge ref_clk);
    proc.baseRom[0] <= 24'h00_0000;
    for (n = 0; n < 3000 && (n == 0 || mLc != 0); n++)
      @(negedge ref_clk);
    @(posedge ref_clk);
    run <= 1'b0;
    $display("run from %h in mode %0d done", s, mMode);
    if (n == 3000)
    begin
      failures++;
      summarize();
    end
  endtask
  task automatic progs();
    put(11'h400, 24'h01_0410);
    put(11'h410, 24'h00_0800);
    put(11'h401, 24'h02_2000);
    put(11'h402, 24'h00_2000);
    put(11'h41B, 24'h00_05EC);
    put(11'h5EC, 24'h00_2000);
    put(11'h420, 24'h00_6012);
    put(11'h421, 24'h00_6034);
    put(11'h422, 24'h00_0302);
    put(11'h5FC, 24'h00_13FE);
  endtask
  // ==========================================================
  // main sequence
  initial
  begin
    logic [31:0] r;
    void'($urandom(32'h6810));
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    wb(0, wcsseq_pkg::REG_CTRL, 0, r);
    chk("ctrl reset", 32'(wcsseq_pkg::CTRL_ENABLE_RESET), (r >> 12) & 32'h0000_0001);
    wb(1, 8'h40, 32'hFFFF_FFFF, r);
    wb(0, 8'h40, 0, r);
    chk("unmapped", wcsseq_pkg::UNMAPPED_READ, r);
    $display("register test done");
    setMode(wcsseq_pkg::SW_MODE_ONE, 1);
    progs();
    load();
    go(11'h400);
    enable();
    go(11'h400);
    go(11'h41B);
    go(11'h420);
    go(11'h5F0);
    sw <= 7'h00;
    mMode = 0;
    repeat (8) @(posedge ref_clk);
    go(11'h400);
    setMode(wcsseq_pkg::SW_MODE_TWO, 2);
    put(11'h600, 24'h1C_2000);
    img[10'h201] = 24'h1C_2000;
    put(11'h602, 24'h00_0000);
    load();
    enable();
    go(11'h600);
    go(11'h780);
    setMode(wcsseq_pkg::SW_MODE_THREE, 3);
    progs();
    load();
    enable();
    go(11'h400);
    go(11'h5F0);
    setMode(wcsseq_pkg::SW_MODE_FOUR, 4);
    put(11'h000, 24'h00_0000);
    put(11'h100, 24'h88_3000);
    proc.baseRom[11'h100] = 24'h04_2000;
    load();
    enable();
    go(11'h100);
    summarize();
  end
endmodule
`default_nettype wire
